// File: logic/pcr_control_reg.sv
// Function
// - bit 15 resets time engine, self clears
// - bit 14 disables classifier/modifier, resets to 1
// - disable rising mid packet takes effect at end
// - disable falling applies from next start of packet
// - bit 13 selects precise-time or circuit emulation
// - bit 12 gates third queue on first-queue news
// - bit 6 selects hash or VLAN ID stored
// - bit 5 powers down and bypasses TX PLL
// - bit 4 stops parallel datapath clocks
// - bit 3 powers down serial transmit path
// - bit 2 powers down serial receive path
// - bit 1 stops classifier/modifier clocks
// - bit 0 stops time engine clocks
module pcr_control_reg
  import pcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic pkt_sop_i,
  input wire logic pkt_eop_i,
  input wire logic first_ts_written_i,
  input wire logic third_ts_request_i,
  output logic [15:0] reg_rdata_o,
  output logic time_engine_soft_reset_o,
  output logic classifier_modifier_disable_o,
  output logic circuit_emulation_mode_o,
  output logic third_queue_write_o,
  output logic vlan_id_to_queue_select_o,
  output pcr_power_t power_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register write path
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] wr_val_w;
  logic [15:0] hold_val_w;
  logic hit_w;
  logic wr_w;
  logic sc_next_w;

  assign hit_w = (reg_addr_i == PTP_CONTROL_ONE_OFS);
  assign wr_w = reg_wr_i && hit_w;
  // reserved bits are never stored, whatever the write carries
  assign wr_val_w = reg_wdata_i & RW_MASK;
  // the self-clearing bit stands only for the cycle after its write
  assign sc_next_w = wr_w && reg_wdata_i[TIME_ENGINE_SOFT_RESET_BIT];

  always_comb begin
    hold_val_w = ctrl_q;
    hold_val_w[TIME_ENGINE_SOFT_RESET_BIT] = 1'b0;
  end

  always_comb begin
    ctrl_d = wr_w ? wr_val_w : hold_val_w;
    ctrl_d[TIME_ENGINE_SOFT_RESET_BIT] = sc_next_w;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= RESET_VAL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read path
  logic [15:0] rdata_q;
  logic [15:0] rd_mux_w;

  // an unmapped read returns zero rather than stale data
  assign rd_mux_w = hit_w ? ctrl_q : '0;

  // self-clearing bit reads back as zero once the pulse is done
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux_w;
    end
  end
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // packet tracking
  pcr_pkt_state_t st_q;
  pcr_pkt_state_t st_d;
  logic in_pkt_w;
  logic pkt_open_w;
  logic pkt_close_w;

  assign in_pkt_w = (st_q == PCR_PKT);
  // a one-cycle packet opens and closes on the same edge
  assign pkt_open_w = pkt_sop_i && !pkt_eop_i;
  assign pkt_close_w = pkt_eop_i;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PCR_IDLE: begin
        if (pkt_open_w) begin
          st_d = PCR_PKT;
        end
      end
      PCR_PKT: begin
        if (pkt_close_w) begin
          st_d = PCR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= PCR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet-boundary handover of the disable bit
  logic dis_q;
  logic dis_d;
  logic dis_req_w;
  logic boundary_w;
  logic rise_ok_w;
  logic fall_ok_w;

  assign dis_req_w = ctrl_q[CM_DIS_BIT];
  // rise: the packet passing keeps its old settings up to its end
  assign boundary_w = !in_pkt_w || pkt_close_w;
  assign rise_ok_w = dis_req_w && boundary_w;
  // fall: a packet in progress stays ignored, so enabling waits for the
  // next start of packet, even when the line is idle
  assign fall_ok_w = !dis_req_w && pkt_sop_i;

  always_comb begin
    dis_d = dis_q;
    if (rise_ok_w) begin
      dis_d = 1'b1;
    end else if (fall_ok_w) begin
      dis_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dis_q <= RESET_VAL[CM_DIS_BIT];
    end else begin
      dis_q <= dis_d;
    end
  end
  assign classifier_modifier_disable_o = dis_q;

  ////////////////////////////////////////////////////////////////////////////
  // third queue gating
  logic news_q;
  logic news_d;
  logic third_wr_q;
  logic gate_on_w;
  logic gate_ok_w;
  logic grant_w;
  logic news_set_w;
  logic news_clr_w;

  assign gate_on_w = ctrl_q[GATE_BIT];
  assign gate_ok_w = !gate_on_w || news_q || first_ts_written_i;
  assign grant_w = third_ts_request_i && gate_ok_w;
  // a grant uses up stored news; a same-cycle first-queue entry is kept
  // for the next grant only when stored news paid for this one
  assign news_clr_w = grant_w;
  assign news_set_w = first_ts_written_i && !(grant_w && !news_q);

  always_comb begin
    news_d = news_q;
    if (news_clr_w) begin
      news_d = 1'b0;
    end
    if (news_set_w) begin
      news_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      news_q <= 1'b0;
      third_wr_q <= 1'b0;
    end else begin
      news_q <= news_d;
      third_wr_q <= grant_w;
    end
  end
  assign third_queue_write_o = third_wr_q;

  ////////////////////////////////////////////////////////////////////////////
  // direct field outputs, all straight from the register
  assign time_engine_soft_reset_o = ctrl_q[TIME_ENGINE_SOFT_RESET_BIT];
  assign circuit_emulation_mode_o = ctrl_q[MODE_BIT];
  assign vlan_id_to_queue_select_o = ctrl_q[VID_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // power-down and clock-stop controls
  pcr_power_t pwr_w;

  assign pwr_w.tx_pll_powerdown = ctrl_q[PLL_BIT];
  assign pwr_w.datapath_powerdown = ctrl_q[DP_BIT];
  assign pwr_w.serial_tx_powerdown = ctrl_q[TX_BIT];
  assign pwr_w.serial_rx_powerdown = ctrl_q[RX_BIT];
  assign pwr_w.packet_logic_powerdown = ctrl_q[PKT_BIT];
  assign pwr_w.time_engine_powerdown = ctrl_q[TE_BIT];
  assign power_o = pwr_w;

endmodule : pcr_control_reg

// File: logic/pcr_pkg.sv
package pcr_pkg;

  // register location and width
  localparam int REG_W = 16;
  localparam logic [7:0] PTP_CONTROL_ONE_OFS = 8'h10;

  // field positions
  localparam int TIME_ENGINE_SOFT_RESET_BIT = 15;
  localparam int CM_DIS_BIT = 14;
  localparam int MODE_BIT = 13;
  localparam int GATE_BIT = 12;
  localparam int VID_BIT = 6;
  localparam int PLL_BIT = 5;
  localparam int DP_BIT = 4;
  localparam int TX_BIT = 3;
  localparam int RX_BIT = 2;
  localparam int PKT_BIT = 1;
  localparam int TE_BIT = 0;

  // writable bits and reset value; bits 11:7 stay zero
  localparam logic [15:0] RW_MASK = 16'h707f;
  localparam logic [15:0] RESET_VAL = 16'h4000;

  typedef struct packed {
    logic tx_pll_powerdown;
    logic datapath_powerdown;
    logic serial_tx_powerdown;
    logic serial_rx_powerdown;
    logic packet_logic_powerdown;
    logic time_engine_powerdown;
  } pcr_power_t;

  typedef enum logic [1:0] {
    PCR_IDLE = 2'b00,
    PCR_PKT = 2'b01
  } pcr_pkt_state_t;

endpackage : pcr_pkg

// File: verif/pcr_control_reg_props.sv
module pcr_control_reg_props
  import pcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic pkt_sop_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic time_engine_soft_reset_o,
  input wire logic circuit_emulation_mode_o,
  input wire logic classifier_modifier_disable_o,
  input wire logic third_ts_request_i,
  input wire logic third_queue_write_o,
  input wire pcr_power_t power_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire hit = reg_wr_i && reg_addr_i == PTP_CONTROL_ONE_OFS;
  sequence rst_wr; hit && reg_wdata_i[TIME_ENGINE_SOFT_RESET_BIT]; endsequence
  a_rst_pulse: assert property (rst_wr |=> time_engine_soft_reset_o)
    else $error("no pulse");
  a_rst_clear: assert property (
    rst_wr ##1 !hit |=> !time_engine_soft_reset_o) else $error("stuck");
  a_power_load: assert property (
    hit |=> power_o == $past(reg_wdata_i[5:0])) else $error("power");
  a_power_hold: assert property (!hit |=> $stable(power_o))
    else $error("power moved");
  a_mode_load: assert property (
    hit |=> circuit_emulation_mode_o == $past(reg_wdata_i[MODE_BIT]))
    else $error("mode");
  a_dis_fall: assert property (
    $fell(classifier_modifier_disable_o) |-> $past(pkt_sop_i))
    else $error("early enable");
  a_queue_cause: assert property (
    third_queue_write_o |-> $past(third_ts_request_i)) else $error("queue");
  a_rd_unmapped: assert property (
    reg_rd_i && reg_addr_i != PTP_CONTROL_ONE_OFS |=> reg_rdata_o == '0)
    else $error("unmapped read");
endmodule : pcr_control_reg_props
bind pcr_control_reg pcr_control_reg_props u_props (.*);

// File: verif/tb_pcr_control_reg.sv
module tb_pcr_control_reg;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'h0, rst_b_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic pkt_sop_i = 1'h0, pkt_eop_i = 1'h0, first_ts_written_i = 1'h0;
  logic third_ts_request_i = 1'h0, time_engine_soft_reset_o, dis;
  logic classifier_modifier_disable_o, circuit_emulation_mode_o;
  logic third_queue_write_o, vlan_id_to_queue_select_o;
  logic [7:0] reg_addr_i = 8'h10, flds;
  logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o;
  pcr_pkg::pcr_power_t power_o;
  int err_count = 0, comparisons = 0;
  assign dis = classifier_modifier_disable_o;
  assign flds = {circuit_emulation_mode_o, vlan_id_to_queue_select_o,
    power_o};
  pcr_control_reg uut (.*);
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge sys_clk_i) s = 1'h1;
    @(negedge sys_clk_i) s = 1'h0;
  endtask : pulse
  task automatic acc(ref logic s, input logic [7:0] a, input logic [15:0] v);
    reg_addr_i = a;
    reg_wdata_i = v;
    pulse(s);
  endtask : acc
  task automatic summarize();
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_b_i = 1'h1;
    acc(reg_rd_i, 8'h10, 16'h0);
    chk(reg_rdata_o, 16'h4000);
    acc(reg_wr_i, 8'h10, 16'hffff);
    chk(time_engine_soft_reset_o, 16'h1);
    chk(flds, 16'hff);
    acc(reg_wr_i, 8'h20, 16'h0);
    chk(time_engine_soft_reset_o, 16'h0);
    acc(reg_rd_i, 8'h10, 16'h0);
    chk(reg_rdata_o, 16'h707f);
    acc(reg_rd_i, 8'h20, 16'h0);
    chk(reg_rdata_o, 16'h0);
    acc(reg_wr_i, 8'h10, 16'h0);
    chk(flds, 16'h0);
    chk(dis, 16'h1);
    // clearing waits for a packet start even when idle
    pulse(pkt_sop_i);
    @(negedge sys_clk_i) chk(dis, 16'h0);
    acc(reg_wr_i, 8'h10, 16'h4000);
    @(negedge sys_clk_i) chk(dis, 16'h0);
    pulse(pkt_eop_i);
    @(negedge sys_clk_i) chk(dis, 16'h1);
    pulse(third_ts_request_i);
    chk(third_queue_write_o, 16'h1);
    acc(reg_wr_i, 8'h10, 16'h5000);
    pulse(third_ts_request_i);
    chk(third_queue_write_o, 16'h0);
    pulse(first_ts_written_i);
    pulse(third_ts_request_i);
    chk(third_queue_write_o, 16'h1);
    summarize();
  end
endmodule : tb_pcr_control_reg
